/* File: hw/iag_unit.sv */
// One integer address unit: register file, address generation, integer ops.
// Assumes the sequencer holds an offered operation until issue_ready_o is high.
`timescale 1ns/10ps
`default_nettype none

module iag_unit import iag_pkg::*; (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                resetn_i,
  // Issue from the sequencer
  input  wire logic                issue_valid_i,
  output logic                     issue_ready_o,
  input  wire iag_op_type          issue_op_i,
  input  wire logic [RF_AW-1:0]    issue_dst_i,
  input  wire logic [RF_AW-1:0]    issue_src_a_i,
  input  wire logic [RF_AW-1:0]    issue_src_b_i,
  input  wire logic [DATA_W-1:0]   issue_imm_i,
  input  wire logic                issue_use_imm_i,
  input  wire logic [CB_SEL_W-1:0] issue_cb_i,
  input  wire logic                issue_circ_i,
  input  wire logic                issue_bitrev_i,
  input  wire iag_size_type        issue_size_i,
  input  wire logic                unaligned_load_buffer_i,
  // Memory bus address
  output logic                     mem_valid_o,
  output logic      [DATA_W-1:0]   mem_addr_o,
  output iag_size_type             mem_size_o,
  output logic                     mem_misalign_o,
  // Result write-back
  output logic                     res_valid_o,
  output logic      [RF_AW-1:0]    res_dst_o,
  output logic      [DATA_W-1:0]   res_data_o,
  // Loop counter
  output logic                     loop_zero_o
);

  // ----------------------------------------------------------------
  // Issue stage
  // ----------------------------------------------------------------
  iag_issue_type     issue_w;
  iag_issue_type     s1_r;
  logic              s1_valid_r;
  logic              s1_stale_r;
  logic              issue_fire;
  logic              exec_fire;
  logic              hazard;
  logic              exec_we;
  logic              exec_mem;
  logic [RF_AW-1:0]  exec_wa;
  logic [DATA_W-1:0] exec_wd;
  logic [DATA_W-1:0] exec_addr;
  logic [DATA_W-1:0] op_a;
  logic [DATA_W-1:0] op_b;
  logic [DATA_W-1:0] alu_res;
  logic [DATA_W-1:0] cur_base;
  logic [DATA_W-1:0] cur_len;
  logic [DATA_W-1:0] next_ptr;
  logic [DATA_W-1:0] addr_pre;
  logic [DATA_W-1:0] addr_post;
  logic [DATA_W-1:0] cb_base_r [NUM_CB];
  logic [DATA_W-1:0] cb_len_r  [NUM_CB];
  logic [DATA_W-1:0] loop_cnt_r;

  iag_rf_if #(.AW(RF_AW), .DW(DATA_W)) rf_bus ();

  iag_regfile #(.WORDS(RF_WORDS), .AW(RF_AW), .DW(DATA_W)) u_rf (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .rf       (rf_bus)
  );

  assign issue_w = '{op: issue_op_i, dst: issue_dst_i, src_a: issue_src_a_i,
                     src_b: issue_src_b_i, imm: issue_imm_i, use_imm: issue_use_imm_i,
                     cb: issue_cb_i, circ: issue_circ_i, bitrev: issue_bitrev_i,
                     size: issue_size_i};

  assign issue_fire = issue_valid_i && issue_ready_o;
  assign exec_fire  = s1_valid_r && !s1_stale_r;

  // A source named by the new operation is still being produced by the one executing
  assign hazard = issue_fire && exec_fire && exec_we &&
                  (issue_w.src_a == exec_wa ||
                   (!issue_w.use_imm && issue_w.src_b == exec_wa));

  // Stalled operation re-reads its sources once the write has landed
  assign rf_bus.ra_a = s1_stale_r ? s1_r.src_a : issue_w.src_a;
  assign rf_bus.ra_b = s1_stale_r ? s1_r.src_b : issue_w.src_b;
  assign rf_bus.we   = exec_fire && exec_we;
  assign rf_bus.wa   = exec_wa;
  assign rf_bus.wd   = exec_wd;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r       <= '0;
      s1_valid_r <= 1'b0;
      s1_stale_r <= 1'b0;
    end else if (issue_fire) begin
      s1_r       <= issue_w;
      s1_valid_r <= 1'b1;
      s1_stale_r <= hazard;
    end else if (s1_stale_r) begin
      s1_stale_r <= 1'b0;
    end else begin
      s1_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      issue_ready_o <= READY_RST;
    end else begin
      issue_ready_o <= !hazard;
    end
  end

  // ----------------------------------------------------------------
  // Execute stage
  // ----------------------------------------------------------------
  assign op_a     = rf_bus.rd_a;
  assign op_b     = s1_r.use_imm ? s1_r.imm : rf_bus.rd_b;
  assign cur_base = cb_base_r[s1_r.cb];
  assign cur_len  = cb_len_r[s1_r.cb];

  iag_addr_calc u_calc (
    .ptr_i       (op_a),
    .mod_i       (op_b),
    .base_i      (cur_base),
    .len_i       (cur_len),
    .circ_i      (s1_r.circ),
    .bitrev_i    (s1_r.bitrev),
    .next_ptr_o  (next_ptr),
    .addr_pre_o  (addr_pre),
    .addr_post_o (addr_post)
  );

  always_comb begin
    alu_res   = '0;
    exec_we   = 1'b0;
    exec_mem  = 1'b0;
    exec_wa   = s1_r.dst;
    exec_wd   = '0;
    exec_addr = '0;
    case (s1_r.op)
      OP_ADD: alu_res = op_a + op_b;
      OP_SUB: alu_res = op_a - op_b;
      OP_AND: alu_res = op_a & op_b;
      OP_OR:  alu_res = op_a | op_b;
      OP_XOR: alu_res = op_a ^ op_b;
      OP_MOV: alu_res = op_b;
      default: alu_res = '0;
    endcase
    case (s1_r.op)
      OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MOV: begin
        exec_we = 1'b1;
        exec_wd = alu_res;
      end
      OP_ADDR_IMM: begin
        exec_mem  = 1'b1;
        exec_addr = s1_r.imm;
      end
      OP_ADDR_PRE: begin
        exec_mem  = 1'b1;
        exec_addr = addr_pre;
        exec_we   = 1'b1;
        exec_wa   = s1_r.src_a;
        exec_wd   = next_ptr;
      end
      OP_ADDR_POST: begin
        exec_mem  = 1'b1;
        exec_addr = addr_post;
        exec_we   = 1'b1;
        exec_wa   = s1_r.src_a;
        exec_wd   = next_ptr;
      end
      default: begin
        exec_we = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Circular buffer and loop registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_CB; i++) begin
        cb_base_r[i] <= WORD_RST;
        cb_len_r[i]  <= WORD_RST;
      end
    end else if (exec_fire && s1_r.op == OP_CB_BASE) begin
      cb_base_r[s1_r.cb] <= op_b;
    end else if (exec_fire && s1_r.op == OP_CB_LEN) begin
      cb_len_r[s1_r.cb] <= op_b;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      loop_cnt_r  <= WORD_RST;
      loop_zero_o <= 1'b1;
    end else if (exec_fire && s1_r.op == OP_LOOP_SET) begin
      loop_cnt_r  <= op_b;
      loop_zero_o <= (op_b == '0);
    end else if (exec_fire && s1_r.op == OP_LOOP_DEC && loop_cnt_r != '0) begin
      loop_cnt_r  <= loop_cnt_r - 1'b1;
      loop_zero_o <= (loop_cnt_r == 32'h0000_0001);
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_valid_o    <= 1'b0;
      mem_addr_o     <= WORD_RST;
      mem_size_o     <= SIZE_WORD;
      mem_misalign_o <= 1'b0;
    end else begin
      mem_valid_o <= exec_fire && exec_mem;
      if (exec_fire && exec_mem) begin
        mem_addr_o     <= exec_addr;
        mem_size_o     <= s1_r.size;
        // Flag only; alignment is the issuer's duty
        mem_misalign_o <= !unaligned_load_buffer_i &&
                          ((s1_r.size == SIZE_DUAL && exec_addr[0]) ||
                           (s1_r.size == SIZE_QUAD && exec_addr[1:0] != 2'h0));
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      res_valid_o <= 1'b0;
      res_dst_o   <= '0;
      res_data_o  <= WORD_RST;
    end else begin
      res_valid_o <= exec_fire && exec_we;
      if (exec_fire && exec_we) begin
        res_dst_o  <= exec_wa;
        res_data_o <= exec_wd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dclk @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  logic ptr_in_buf;
  logic mod_small;
  assign ptr_in_buf = ({1'b0, op_a} >= {1'b0, cur_base}) &&
                      ({1'b0, op_a} < ({1'b0, cur_base} + {1'b0, cur_len}));
  assign mod_small  = op_b[DATA_W-1] ? ((-op_b) <= cur_len) : (op_b <= cur_len);

  property p_pre_writeback;
    exec_fire && s1_r.op == OP_ADDR_PRE && !s1_r.bitrev |=>
      res_valid_o && mem_valid_o && res_data_o == mem_addr_o && res_dst_o == $past(s1_r.src_a);
  endproperty
  a_pre_writeback: assert property (p_pre_writeback) else $error("pre-modify mismatch");

  property p_post_addr;
    exec_fire && s1_r.op == OP_ADDR_POST && !s1_r.bitrev |=> mem_addr_o == $past(op_a);
  endproperty
  a_post_addr: assert property (p_post_addr) else $error("post-modify address wrong");

  property p_imm_addr;
    exec_fire && s1_r.op == OP_ADDR_IMM |=> mem_valid_o && !res_valid_o &&
                                           mem_addr_o == $past(s1_r.imm);
  endproperty
  a_imm_addr: assert property (p_imm_addr) else $error("immediate address wrong");

  property p_circ_in_range;
    exec_fire && s1_r.op inside {OP_ADDR_PRE, OP_ADDR_POST} && s1_r.circ &&
    ptr_in_buf && mod_small && !cur_base[DATA_W-1] && !cur_len[DATA_W-1] |=>
      res_data_o >= $past(cur_base) && res_data_o < $past(cur_base + cur_len);
  endproperty
  a_circ_in_range: assert property (p_circ_in_range) else $error("pointer left buffer");

  property p_stall;
    hazard |=> !issue_ready_o ##1 issue_ready_o && exec_fire;
  endproperty
  a_stall: assert property (p_stall) else $error("dependency stall wrong");

  property p_next_cycle;
    issue_fire && !hazard && !s1_stale_r && issue_w.op inside {OP_ADD, OP_SUB, OP_MOV} |=>
      exec_fire ##1 res_valid_o && res_dst_o == $past(issue_w.dst, 2);
  endproperty
  a_next_cycle: assert property (p_next_cycle) else $error("result not one stage");

  property p_size;
    exec_fire && exec_mem |=> mem_size_o == $past(s1_r.size);
  endproperty
  a_size: assert property (p_size) else $error("access size lost");

  property p_loop_zero;
    exec_fire && s1_r.op == OP_LOOP_DEC && loop_cnt_r == 32'h0000_0002 |=>
      !loop_zero_o && loop_cnt_r == 32'h0000_0001;
  endproperty
  a_loop_zero: assert property (p_loop_zero) else $error("loop count wrong");

  property p_bitrev;
    exec_fire && s1_r.op == OP_ADDR_PRE && s1_r.bitrev |=>
      mem_addr_o == $past(cur_base) + iag_bit_rev(res_data_o);
  endproperty
  a_bitrev: assert property (p_bitrev) else $error("bit-reverse address wrong");

  property p_add;
    exec_fire && s1_r.op == OP_ADD |=> res_data_o == $past(op_a) + $past(op_b);
  endproperty
  a_add: assert property (p_add) else $error("integer add wrong");

  c_stall:   cover property (hazard ##2 exec_fire);
  c_wrap:    cover property (exec_fire && s1_r.circ && next_ptr != op_a + op_b);
  c_bitrev:  cover property (exec_fire && exec_mem && s1_r.bitrev);
  c_loop:    cover property (exec_fire && s1_r.op == OP_LOOP_DEC ##1 loop_zero_o);

endmodule : iag_unit

`default_nettype wire

/* File: hw/iag_pkg.sv */
// Shared constants, types and helpers of the integer address unit.
// Assumes one core clock and an active-low asynchronous core reset.
// Notes on behaviour
// - Each unit owns a 31-word register file for pointers, modifiers, operands.
// - Address operations emit an address; pre- and post-modify ones also write the updated pointer back.
// - Immediate, pre-modify and post-modify indirect addressing are supported.
// - Modulus and bit-reverse addressing need no base alignment.
// - Each access carries a size: one, two or four words.
// - Four circular buffers per unit, eight across the pair.
// - Pointers past a buffer boundary wrap in hardware automatically.
// - Circular buffers may start and end at any address.
// - General integer arithmetic and logic on register file contents.
// - One-stage pipeline: results usable by the next issued operation.
// - Dependency check takes a dependent operation, delays it one cycle until a needed result exists, and stalls the next issue.
// - Hardware circular, bit-reverse and zero-overhead loop counting.

package iag_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int DATA_W   = 32;
  localparam int RF_WORDS = 31;
  localparam int RF_AW    = 5;
  localparam int NUM_CB   = 4;
  localparam int CB_SEL_W = 2;

  localparam logic              READY_RST = 1'b1;
  localparam logic [DATA_W-1:0] WORD_RST  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Operations and access sizes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MOV,
    OP_ADDR_IMM, OP_ADDR_PRE, OP_ADDR_POST,
    OP_CB_BASE, OP_CB_LEN, OP_LOOP_SET, OP_LOOP_DEC
  } iag_op_type;

  typedef enum logic [1:0] {SIZE_WORD, SIZE_DUAL, SIZE_QUAD} iag_size_type;

  typedef struct packed {
    iag_op_type          op;
    logic [RF_AW-1:0]    dst;
    logic [RF_AW-1:0]    src_a;
    logic [RF_AW-1:0]    src_b;
    logic [DATA_W-1:0]   imm;
    logic                use_imm;
    logic [CB_SEL_W-1:0] cb;
    logic                circ;
    logic                bitrev;
    iag_size_type        size;
  } iag_issue_type;

  function automatic logic [DATA_W-1:0] iag_bit_rev(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W; i++) begin
      r[i] = v[DATA_W-1-i];
    end
    return r;
  endfunction : iag_bit_rev

endpackage : iag_pkg

/* File: hw/iag_rf_if.sv */
// Register file port bundle between the unit and its register file.
// Assumes both sides run on the same core clock.
`timescale 1ns/10ps
`default_nettype none

interface iag_rf_if #(
  parameter int AW = 5,
  parameter int DW = 32
);
  logic          we;
  logic [AW-1:0] wa;
  logic [DW-1:0] wd;
  logic [AW-1:0] ra_a;
  logic [AW-1:0] ra_b;
  logic [DW-1:0] rd_a;
  logic [DW-1:0] rd_b;

  modport unit (output we, wa, wd, ra_a, ra_b, input rd_a, rd_b);
  modport rf   (input we, wa, wd, ra_a, ra_b, output rd_a, rd_b);
endinterface : iag_rf_if

`default_nettype wire

/* File: hw/iag_regfile.sv */
// Pointer and operand register file with two registered read ports.
// Assumes reads see the value before a same-edge write; top index reads zero.
`timescale 1ns/10ps
`default_nettype none

module iag_regfile #(
  parameter int WORDS = 31,
  parameter int AW    = 5,
  parameter int DW    = 32
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic resetn_i,
  // Register file bundle
  iag_rf_if.rf      rf
);
  localparam logic [AW-1:0] LAST_IDX = AW'(WORDS - 1);

  logic [DW-1:0] mem_r [WORDS];

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_r[i] <= '0;
      end
    end else if (rf.we && rf.wa <= LAST_IDX) begin
      mem_r[rf.wa] <= rf.wd;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rf.rd_a <= '0;
      rf.rd_b <= '0;
    end else begin
      rf.rd_a <= (rf.ra_a <= LAST_IDX) ? mem_r[rf.ra_a] : '0;
      rf.rd_b <= (rf.ra_b <= LAST_IDX) ? mem_r[rf.ra_b] : '0;
    end
  end
endmodule : iag_regfile

`default_nettype wire

/* File: hw/iag_addr_calc.sv */
// Pointer modify with circular wrap and bit-reversed address forming.
// Assumes the modify value is two's complement and length fits the buffer.
`timescale 1ns/10ps
`default_nettype none

module iag_addr_calc import iag_pkg::*; (
  // Operands
  input  wire logic [DATA_W-1:0] ptr_i,
  input  wire logic [DATA_W-1:0] mod_i,
  input  wire logic [DATA_W-1:0] base_i,
  input  wire logic [DATA_W-1:0] len_i,
  // Mode
  input  wire logic              circ_i,
  input  wire logic              bitrev_i,
  // Results
  output logic      [DATA_W-1:0] next_ptr_o,
  output logic      [DATA_W-1:0] addr_pre_o,
  output logic      [DATA_W-1:0] addr_post_o
);
  logic [DATA_W:0]   sum_x;
  logic [DATA_W:0]   end_x;
  logic [DATA_W-1:0] sum;
  logic              wrap_hi;
  logic              wrap_lo;

  always_comb begin
    sum_x   = {1'b0, ptr_i} + {mod_i[DATA_W-1], mod_i};
    end_x   = {1'b0, base_i} + {1'b0, len_i};
    sum     = sum_x[DATA_W-1:0];
    // Any base and length: plain compares, no power-of-two masks
    wrap_hi = circ_i && !mod_i[DATA_W-1] && (sum_x >= end_x);
    wrap_lo = circ_i && mod_i[DATA_W-1] && (sum_x[DATA_W] || sum < base_i);
    if (wrap_hi) begin
      next_ptr_o = sum - len_i;
    end else if (wrap_lo) begin
      next_ptr_o = sum + len_i;
    end else begin
      next_ptr_o = sum;
    end
    addr_pre_o  = bitrev_i ? base_i + iag_bit_rev(next_ptr_o) : next_ptr_o;
    addr_post_o = bitrev_i ? base_i + iag_bit_rev(ptr_i) : ptr_i;
  end
endmodule : iag_addr_calc

`default_nettype wire

/* File: test/iag_seq_model.sv */
// Sequencer stand-in that offers one operation at a time to an address unit.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module iag_seq_model import iag_pkg::*; (
  // Clock
  input  wire logic        clock_i,
  // Issue handshake
  input  wire logic        ready_i,
  output logic             valid_o,
  output var iag_issue_type op_o
);
  initial begin
    valid_o = 1'b0;
    op_o    = '0;
  end

  // Holds the offer until ready is seen high at a falling edge, then returns after the next rising edge
  task automatic issue(input iag_issue_type t, output int stalls);
    logic rdy;
    stalls  = 0;
    valid_o <= 1'b1;
    op_o    <= t;
    for (int i = 0; i < 16; i++) begin
      @(negedge clock_i);
      rdy = ready_i;
      @(posedge clock_i);
      if (rdy === 1'b1)
        return;
      stalls++;
    end
    stalls = -1;
  endtask : issue

  // Released fields show garbage, not the last offer
  task automatic idle();
    valid_o <= 1'b0;
    op_o    <= iag_issue_type'(~op_o);
    @(posedge clock_i);
  endtask : idle
endmodule : iag_seq_model

`default_nettype wire

/* File: test/tb_integer_address_generator.sv */
// Self-checking bench for one integer address unit.
// Assumes the unit answers one cycle after an operation is taken.
`timescale 1ns/10ps
`default_nettype none

module tb_integer_address_generator import iag_pkg::*; ;
  logic clock_i, resetn_i, seq_valid, ulb, issue_ready_o, mem_valid_o, mem_misalign_o;
  logic res_valid_o, loop_zero_o;
  logic [4:0] res_dst_o;
  logic [31:0] mem_addr_o, res_data_o;
  iag_size_type mem_size_o;
  iag_issue_type seq_op;
  logic [31:0] rf_m[32], cb_b[4], cb_l[4];
  logic [34:0] mem_q[$];
  logic [36:0] res_q[$];
  integer seed, bad_count, checks, stall_n;
  iag_op_type lp_op[5] = '{OP_LOOP_SET, OP_LOOP_DEC, OP_LOOP_DEC, OP_LOOP_DEC, OP_LOOP_SET};
  logic [31:0] lp_val[5] = '{32'h2, 32'h0, 32'h0, 32'h0, 32'h5};
  logic lp_exp[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  iag_seq_model u_seq (.clock_i(clock_i), .ready_i(issue_ready_o), .valid_o(seq_valid),
    .op_o(seq_op));
  iag_unit DUT (.clock_i(clock_i), .resetn_i(resetn_i), .issue_valid_i(seq_valid),
    .issue_ready_o(issue_ready_o), .issue_op_i(seq_op.op), .issue_dst_i(seq_op.dst),
    .issue_src_a_i(seq_op.src_a), .issue_src_b_i(seq_op.src_b), .issue_imm_i(seq_op.imm),
    .issue_use_imm_i(seq_op.use_imm), .issue_cb_i(seq_op.cb), .issue_circ_i(seq_op.circ),
    .issue_bitrev_i(seq_op.bitrev), .issue_size_i(seq_op.size),
    .unaligned_load_buffer_i(ulb), .mem_valid_o(mem_valid_o), .mem_addr_o(mem_addr_o),
    .mem_size_o(mem_size_o), .mem_misalign_o(mem_misalign_o), .res_valid_o(res_valid_o),
    .res_dst_o(res_dst_o), .res_data_o(res_data_o), .loop_zero_o(loop_zero_o));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic note(input string n, input logic [36:0] e, g);
    checks++;
    if (e !== g) begin
      bad_count++;
      $display("Error %s expected %h got %h", n, e, g);
    end
  endtask : note

  task automatic cmp_mem(input logic [34:0] e, g);
    note("mem_addr_size_misalign", 37'(e), 37'(g));
  endtask : cmp_mem

  task automatic cmp_res(input logic [36:0] e, g);
    note("res_dst_data", e, g);
  endtask : cmp_res

  task automatic cmp_bit(input string n, input logic e, g);
    note(n, 37'(e), 37'(g));
  endtask : cmp_bit

  // Oldest expectation is taken off whenever a result pulse shows
  always @(negedge clock_i) begin
    if (resetn_i === 1'b1 && mem_valid_o === 1'b1) begin
      if (mem_q.size() == 0)
        cmp_bit("mem_extra", 1'b0, 1'b1);
      else
        cmp_mem(mem_q.pop_front(), {mem_addr_o, mem_size_o, mem_misalign_o});
    end
    if (resetn_i === 1'b1 && res_valid_o === 1'b1) begin
      if (res_q.size() == 0)
        cmp_bit("res_extra", 1'b0, 1'b1);
      else
        cmp_res(res_q.pop_front(), {res_dst_o, res_data_o});
    end
  end

  // ----------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rev32(input logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 32; i++)
      r[i] = v[31-i];
    return r;
  endfunction : rev32

  function automatic logic [31:0] alu(input iag_op_type op, input logic [31:0] a, b);
    case (op)
      OP_ADD: return a + b;
      OP_SUB: return a - b;
      OP_AND: return a & b;
      OP_OR: return a | b;
      default: return a ^ b;
    endcase
  endfunction : alu

  task automatic run(input iag_op_type op, input logic [4:0] d, a, b, input logic [31:0] imm,
      input logic ui = 1'b1, input logic [1:0] cb = 2'h0, input logic ci = 1'b0,
      input logic br = 1'b0, input iag_size_type sz = SIZE_WORD);
    u_seq.issue('{op, d, a, b, imm, ui, cb, ci, br, sz}, stall_n);
    if (stall_n < 0) begin
      cmp_bit("issue_timeout", 1'b1, 1'b0);
      end_of_test();
    end
  endtask : run

  task automatic exp_res(input logic [4:0] d, input logic [31:0] v);
    res_q.push_back({d, v});
    rf_m[d] = v;
  endtask : exp_res

  task automatic setr(input logic [4:0] d, input logic [31:0] v);
    exp_res(d, v);
    run(OP_ADD, d, 5'h1f, 5'h0, v);
  endtask : setr

  task automatic alu_op(input iag_op_type op, input logic [4:0] d, a, b);
    exp_res(d, alu(op, rf_m[a], rf_m[b]));
    run(op, d, a, b, 32'h0, 1'b0);
  endtask : alu_op

  task automatic set_cb(input logic [1:0] c, input logic [31:0] b, l);
    cb_b[c] = b;
    cb_l[c] = l;
    run(OP_CB_BASE, 5'h0, 5'h1f, 5'h0, b, 1'b1, c);
    run(OP_CB_LEN, 5'h0, 5'h1f, 5'h0, l, 1'b1, c);
  endtask : set_cb

  task automatic addr_op(input iag_op_type op, input logic [4:0] p, input logic [31:0] m,
      input logic [1:0] cb = 2'h0, input logic ci = 1'b0, input logic br = 1'b0,
      input iag_size_type sz = SIZE_WORD);
    logic [31:0] old, nw, ad;
    old = rf_m[p];
    nw = old + m;
    if (ci && !m[31] && nw >= cb_b[cb] + cb_l[cb])
      nw = nw - cb_l[cb];
    if (ci && m[31] && nw < cb_b[cb])
      nw = nw + cb_l[cb];
    ad = (op == OP_ADDR_PRE) ? nw : old;
    if (br)
      ad = cb_b[cb] + rev32(ad);
    mem_q.push_back({ad, sz, ((sz == SIZE_DUAL && ad[0]) ||
      (sz == SIZE_QUAD && ad[1:0] != 2'h0)) && !ulb});
    exp_res(p, nw);
    run(op, 5'h0, p, 5'h0, m, 1'b1, cb, ci, br, sz);
  endtask : addr_op

  task automatic drain();
    u_seq.idle();
    for (int i = 0; i < 50; i++) begin
      if (mem_q.size() == 0 && res_q.size() == 0)
        return;
      @(posedge clock_i);
    end
    cmp_bit("drain", 1'b1, 1'b0);
    end_of_test();
  endtask : drain

  initial begin
    seed = 32'h0e52b24b;
    bad_count = 0;
    checks = 0;
    resetn_i = 1'b0;
    ulb = 1'b0;
    for (int i = 0; i < 32; i++)
      rf_m[i] = '0;
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(negedge clock_i);
    cmp_bit("ready_rst", READY_RST, issue_ready_o);
    cmp_bit("loop_rst", 1'b1, loop_zero_o);
    @(posedge clock_i);
    for (int i = 0; i < 31; i++)
      setr(5'(i), $random(seed));
    for (int i = 0; i < 31; i++)
      alu_op(OP_ADD, 5'(i), 5'(i), 5'h1f);
    for (int k = 0; k < 5; k++)
      alu_op(iag_op_type'(k + 1), 5'ha, 5'h1, 5'h2);
    cmp_bit("no_stall", 1'b1, stall_n == 0);
    alu_op(OP_ADD, 5'h3, 5'h1, 5'h0);
    alu_op(OP_ADD, 5'h5, 5'h3, 5'h1f);
    cmp_bit("dep_taken", 1'b1, stall_n == 0);
    // The dependent op is taken at once; the next offer sees the one-cycle stall
    alu_op(OP_XOR, 5'hb, 5'h1, 5'h2);
    cmp_bit("stall", 1'b1, stall_n == 1);
    for (int k = 0; k < 6; k++) begin
      if (k == 3) begin
        drain();
        ulb <= 1'b1;
        u_seq.idle();
      end
      addr_op(OP_ADDR_PRE, 5'h6, $random(seed) & 32'hf, 2'h0, 1'b0, 1'b0,
        iag_size_type'(k % 3));
      addr_op(OP_ADDR_POST, 5'h6, $random(seed) & 32'hf, 2'h0, 1'b0, 1'b0,
        iag_size_type'(k % 3));
    end
    mem_q.push_back({32'h0000_1234, SIZE_QUAD, 1'b0});
    run(OP_ADDR_IMM, 5'h0, 5'h0, 5'h0, 32'h0000_1234, 1'b1, 2'h0, 1'b0, 1'b0, SIZE_QUAD);
    for (int c = 0; c < 4; c++) begin
      set_cb(2'(c), 32'h0000_0103 + 32'(c * 65), 32'(10 + c));
      setr(5'h7, cb_b[c] + cb_l[c] - 32'h2);
      addr_op(OP_ADDR_POST, 5'h7, 32'h3, 2'(c), 1'b1);
      addr_op(OP_ADDR_PRE, 5'h7, 32'hffff_fffd, 2'(c), 1'b1);
      addr_op(OP_ADDR_PRE, 5'h7, 32'h2, 2'(c), 1'b1);
    end
    setr(5'h8, $random(seed) & 32'hff);
    addr_op(OP_ADDR_PRE, 5'h8, 32'h4, 2'h2, 1'b0, 1'b1);
    addr_op(OP_ADDR_POST, 5'h8, 32'h1, 2'h2, 1'b0, 1'b1);
    for (int k = 0; k < 5; k++) begin
      run(lp_op[k], 5'h0, 5'h1f, 5'h0, lp_val[k]);
      u_seq.idle();
      @(negedge clock_i);
      cmp_bit("loop_zero", lp_exp[k], loop_zero_o);
      @(posedge clock_i);
    end
    drain();
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 32; i++)
      rf_m[i] = '0;
    @(negedge clock_i);
    cmp_bit("loop_rst2", 1'b1, loop_zero_o);
    @(posedge clock_i);
    alu_op(OP_ADD, 5'h9, 5'h1, 5'h1f);
    drain();
    end_of_test();
  end
endmodule : tb_integer_address_generator

`default_nettype wire
